// *** verilog/cpe_pkg.sv ***
/*
 * Constants for the CPU exception and interrupt priority unit: register
 * offsets, reset values, vector numbers, priority levels and states.
 * Assumes a 32-bit APB register bus and a 32-bit CPU memory port.
 */
package cpe_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_VBASE = 8'h00;
	localparam logic [7:0] OFF_SWORD = 8'h04;
	localparam logic [7:0] OFF_PRIO0 = 8'h08;
	localparam logic [7:0] OFF_PEND = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1C;
	localparam int NPRIO = 4;
	// Reset values
	localparam logic [31:0] VBASE_RST = 32'h0000_0000;
	localparam logic [31:0] SWORD_RST = 32'h0000_00F0;
	localparam logic [3:0] MASK_ONES = 4'hF;
	localparam int MASK_LSB = 4;
	// Vector table
	localparam logic [31:0] RESET_BASE = 32'hA000_0000;
	localparam logic [31:0] SP_STEP = 32'h0000_0004;
	localparam logic [7:0] VEC_RST_PC = 8'h00;
	localparam logic [7:0] VEC_RST_SP = 8'h01;
	localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
	localparam logic [7:0] VEC_NMI = 8'h0B;
	localparam logic [7:0] VEC_BRK = 8'h0C;
	localparam logic [7:0] VEC_DBG = 8'h0D;
	localparam logic [7:0] VEC_IRQ_LO = 8'h40;
	localparam logic [7:0] VEC_IRQ_HI = 8'h50;
	localparam logic [7:0] VEC_PER = 8'h54;
	localparam int IRQ_SPLIT = 4;
	// Source indices and levels
	localparam int SRC_NMI = 0;
	localparam int SRC_BRK = 1;
	localparam int SRC_DBG = 2;
	localparam int SRC_IRQ0 = 3;
	localparam logic [4:0] LVL_NMI = 5'h10;
	localparam logic [4:0] LVL_FIX = 5'h0F;
	// Access kinds from the core
	typedef enum logic [1:0] {
		ACC_FETCH, ACC_BYTE, ACC_WORD, ACC_LONG
	} cpe_acc_e;
	typedef enum logic [1:0] {
		CAUSE_RST, CAUSE_AE, CAUSE_INT
	} cpe_cause_e;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RPC, ST_RSP, ST_PUSH_SR, ST_PUSH_PC, ST_VEC, ST_LOAD
	} cpe_state_e;
endpackage

// *** verilog/cpe_exc_unit.sv ***
/*
 * CPU exception unit: debug-initiated reset sequence, alignment checks
 * raising address errors, and interrupt priority resolution with the
 * stacking and vector fetch that follow acceptance.
 * Assumes an APB master, a core that reports accesses and instruction
 * completion, and a memory port that acknowledges each request.
 */
// Local design decisions: the placing of the registers and the APB slave port.
// Contract
// RULE1 - Debug reset command starts reset exception handling.
// RULE2 - Reset fetches initial PC, then initial SP, then loads both.
// RULE3 - Reset clears vector base and sets mask field to all ones.
// RULE4 - Odd instruction fetch address raises an address error.
// RULE5 - Odd word data access raises an address error.
// RULE6 - Longword access off a four-byte boundary raises address error.
// RULE7 - Address error waits for bus cycle and instruction to finish.
// RULE8 - Address error pushes status word first, then program counter.
// RULE9 - Pushed PC is faulting instruction, or the branch if in slot.
// RULE10 - Then fetch address-error vector and jump, no delay slot.
// RULE11 - Requests: NMI pin, break, debug, eight pins, peripherals.
// RULE12 - Peripherals supply twenty-three sources in the listed groups.
// RULE13 - Each source has its own vector number and table offset.
// RULE14 - Pending requests are compared and the winner is handled.
// RULE15 - Priority levels run 0 to 16, 16 highest.
// RULE16 - NMI is level 16 and always accepted.
// RULE17 - Break and debug interrupts are fixed level 15, maskable.
// RULE18 - Pin and peripheral levels programmable 0 to 15 only.
// RULE19 - Maskable request accepted only if level exceeds mask field.
// RULE20 - Acceptance stacks status and PC, then mask takes level. For NMI the code sets the mask to 15.
// RULE21 - Non-reset vector address is vector base plus number times 4.
// RULE22 - Reset vector address is A0000000 plus number times 4.
// RULE23 - Masked requests stay pending and are re-evaluated each cycle.
// RULE24 - Equal levels resolved by fixed source order, lowest index.
`timescale 1ns/1ps
module cpe_exc_unit import cpe_pkg::*; #(
	parameter int NIRQ = 8,
	parameter int NPER = 23
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt and reset requesters
	input wire logic nmi_pin,
	input wire logic brk_req,
	input wire logic dbg_req,
	input wire logic [NIRQ-1:0] irq_pins,
	input wire logic [NPER-1:0] per_req,
	input wire logic dbg_reset_cmd,
	// Core access reports
	input wire logic acc_valid,
	input wire logic [1:0] acc_kind,
	input wire logic [31:0] acc_addr,
	input wire logic [31:0] insn_pc,
	input wire logic insn_in_slot,
	input wire logic [31:0] slot_branch_pc,
	input wire logic [31:0] next_pc,
	input wire logic insn_done,
	input wire logic [31:0] sp_in,
	// Memory port for stacking and vector fetch
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Results to the core
	output logic core_busy,
	output logic core_load,
	output logic [31:0] core_pc,
	output logic [31:0] core_sp,
	output logic int_ack,
	output logic [5:0] int_ack_src
);
	localparam int NSRC = SRC_IRQ0 + NIRQ + NPER;
	localparam int SRC_PER0 = SRC_IRQ0 + NIRQ;
	function automatic logic [31:0] vaddr(input logic [31:0] base,
		input logic [7:0] vec);
		vaddr = base + {22'h0, vec, 2'b00}; // [RULE21] [RULE22]
	endfunction
	function automatic logic [7:0] vec_of(input int i);
		if (i == SRC_NMI)
			vec_of = VEC_NMI;
		else if (i == SRC_BRK)
			vec_of = VEC_BRK;
		else if (i == SRC_DBG)
			vec_of = VEC_DBG;
		else if (i < SRC_IRQ0 + IRQ_SPLIT)
			vec_of = VEC_IRQ_LO + 8'(i - SRC_IRQ0);
		else if (i < SRC_PER0)
			vec_of = VEC_IRQ_HI + 8'(i - SRC_IRQ0 - IRQ_SPLIT);
		else
			vec_of = VEC_PER + 8'(i - SRC_PER0); // [RULE13]
	endfunction
	cpe_state_e state_q, state_d;
	cpe_cause_e cause_q, cause_d;
	logic [31:0] vbase_q, vbase_d;
	logic [31:0] sword_q, sword_d;
	logic [NPRIO*32-1:0] prio_q;
	logic [31:0] sp_q, sp_d;
	logic [31:0] pc_tmp_q, pc_tmp_d;
	logic [31:0] pc_save_q, pc_save_d;
	logic [31:0] sr_save_q, sr_save_d;
	logic [7:0] vec_q, vec_d;
	logic [3:0] newmask_q, newmask_d;
	logic ae_pend_q;
	logic [31:0] ae_pc_q;
	logic nmi_q, nmi_prev_q;
	logic load_q, ack_q;
	logic [5:0] ack_src_q;
	// Bus decode
	wire apb_acc = psel & penable & ce;
	wire apb_wr = apb_acc & pwrite;
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_vb = aligned & (paddr == OFF_VBASE);
	wire hit_sw = aligned & (paddr == OFF_SWORD);
	wire hit_pr = aligned & (paddr >= OFF_PRIO0) &
		(paddr < OFF_PRIO0 + 8'(NPRIO * 4));
	wire hit_pd = aligned & (paddr == OFF_PEND);
	wire hit_st = aligned & (paddr == OFF_STAT);
	wire hit_any = hit_vb | hit_sw | hit_pr | hit_pd | hit_st;
	wire [7:0] pr_off = paddr - OFF_PRIO0;
	wire [1:0] pr_idx = pr_off[3:2];
	wire [3:0] mask = sword_q[MASK_LSB +: 4];
	wire idle = (state_q == ST_IDLE);
	// Request gathering
	wire nmi_edge = nmi_pin & ~nmi_prev_q;
	wire [NSRC-1:0] req = {per_req, irq_pins, dbg_req, brk_req, nmi_q}; // [RULE11] [RULE12]
	logic [4:0] lvl [NSRC];
	logic [5:0] win_idx;
	logic [4:0] win_lvl;
	logic win_ok;
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			if (i == SRC_NMI)
				lvl[i] = LVL_NMI; // [RULE16] [RULE15]
			else if (i < SRC_IRQ0)
				lvl[i] = LVL_FIX; // [RULE17]
			else
				// Four-bit field cannot express 16
				lvl[i] = {1'b0, prio_q[(i-SRC_IRQ0)*4 +: 4]}; // [RULE18]
		end
	end

	// Descending scan with >= lets the lowest index win a tie
	always_comb begin
		win_idx = 6'h00;
		win_lvl = 5'h00;
		win_ok = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i] && (i == SRC_NMI || lvl[i] > {1'b0, mask}) &&
				lvl[i] >= win_lvl) begin // [RULE19] [RULE14] [RULE24]
				win_ok = 1'b1;
				win_idx = 6'(i);
				win_lvl = lvl[i];
			end
		end
	end

	// Alignment check
	wire ae_hit = acc_valid & (
		((acc_kind == ACC_FETCH) & acc_addr[0]) | // [RULE4]
		((acc_kind == ACC_WORD) & acc_addr[0]) | // [RULE5]
		((acc_kind == ACC_LONG) & (acc_addr[1:0] != 2'b00))); // [RULE6]
	wire ae_take = idle & ~dbg_reset_cmd & ae_pend_q & insn_done; // [RULE7]
	wire int_take = idle & ~dbg_reset_cmd & ~ae_pend_q & win_ok &
		insn_done; // [RULE23]
	wire nmi_take = int_take & (win_idx == 6'(SRC_NMI));

	// Memory port
	assign mem_req = ~idle & (state_q != ST_LOAD);
	assign mem_we = (state_q == ST_PUSH_SR) | (state_q == ST_PUSH_PC);
	assign mem_addr = (state_q == ST_RPC) ? vaddr(RESET_BASE, VEC_RST_PC) :
		(state_q == ST_RSP) ? vaddr(RESET_BASE, VEC_RST_SP) :
		(state_q == ST_VEC) ? vaddr(vbase_q, vec_q) :
		sp_q - SP_STEP;
	assign mem_wdata = (state_q == ST_PUSH_SR) ? sr_save_q : pc_save_q;

	// Sequencer
	always_comb begin
		state_d = state_q;
		cause_d = cause_q;
		vbase_d = vbase_q;
		sword_d = sword_q;
		sp_d = sp_q;
		pc_tmp_d = pc_tmp_q;
		pc_save_d = pc_save_q;
		sr_save_d = sr_save_q;
		vec_d = vec_q;
		newmask_d = newmask_q;
		if (apb_wr && hit_vb)
			vbase_d = pwdata;
		if (apb_wr && hit_sw)
			sword_d = pwdata;
		case (state_q)
		ST_IDLE: begin
			if (ae_take) begin
				cause_d = CAUSE_AE;
				pc_save_d = ae_pc_q;
				sr_save_d = sword_q;
				sp_d = sp_in;
				vec_d = VEC_ADDR_ERR;
				state_d = ST_PUSH_SR;
			end else if (int_take) begin
				cause_d = CAUSE_INT;
				pc_save_d = next_pc;
				sr_save_d = sword_q;
				sp_d = sp_in;
				vec_d = vec_of(int'(win_idx));
				// NMI leaves the mask at 15, not 16
				newmask_d = (win_lvl == LVL_NMI) ? MASK_ONES :
					win_lvl[3:0]; // [RULE20]
				state_d = ST_PUSH_SR;
			end
		end
		ST_RPC: begin
			if (mem_ack) begin
				pc_tmp_d = mem_rdata; // [RULE2]
				state_d = ST_RSP;
			end
		end
		ST_RSP: begin
			if (mem_ack) begin
				sp_d = mem_rdata; // [RULE2]
				state_d = ST_LOAD;
			end
		end
		ST_PUSH_SR: begin
			if (mem_ack) begin
				sp_d = sp_q - SP_STEP; // [RULE8]
				state_d = ST_PUSH_PC;
			end
		end
		ST_PUSH_PC: begin
			if (mem_ack) begin
				sp_d = sp_q - SP_STEP; // [RULE8]
				if (cause_q == CAUSE_INT)
					sword_d[MASK_LSB +: 4] = newmask_q; // [RULE20]
				state_d = ST_VEC;
			end
		end
		ST_VEC: begin
			if (mem_ack) begin
				pc_tmp_d = mem_rdata; // [RULE10]
				state_d = ST_LOAD;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
		// Reset outranks every other exception, even mid-sequence
		if (dbg_reset_cmd) begin // [RULE1]
			cause_d = CAUSE_RST;
			vbase_d = VBASE_RST; // [RULE3]
			sword_d = SWORD_RST; // [RULE3]
			state_d = ST_RPC;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cause_q <= CAUSE_RST;
			vbase_q <= VBASE_RST;
			sword_q <= SWORD_RST;
			sp_q <= 32'h0000_0000;
			pc_tmp_q <= 32'h0000_0000;
			pc_save_q <= 32'h0000_0000;
			sr_save_q <= 32'h0000_0000;
			vec_q <= 8'h00;
			newmask_q <= 4'h0;
		end else if (ce) begin
			state_q <= state_d;
			cause_q <= cause_d;
			vbase_q <= vbase_d;
			sword_q <= sword_d;
			sp_q <= sp_d;
			pc_tmp_q <= pc_tmp_d;
			pc_save_q <= pc_save_d;
			sr_save_q <= sr_save_d;
			vec_q <= vec_d;
			newmask_q <= newmask_d;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prio_q <= '0;
		else if (ce) begin
			if (dbg_reset_cmd)
				prio_q <= '0;
			else if (apb_wr && hit_pr)
				prio_q[pr_idx*32 +: 32] <= pwdata;
		end
	end
	// A new fault in the taking cycle is kept: set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ae_pend_q <= 1'b0;
			ae_pc_q <= 32'h0000_0000;
		end else if (ce) begin
			if (dbg_reset_cmd) begin
				ae_pend_q <= 1'b0;
			end else if (ae_hit && (!ae_pend_q || ae_take)) begin
				ae_pend_q <= 1'b1;
				ae_pc_q <= insn_in_slot ? slot_branch_pc : insn_pc; // [RULE9]
			end else if (ae_take) begin
				ae_pend_q <= 1'b0;
			end
		end
	end
	// NMI is edge-caught and held until accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_q <= 1'b0;
			nmi_prev_q <= 1'b0;
		end else if (ce) begin
			nmi_prev_q <= nmi_pin;
			if (dbg_reset_cmd)
				nmi_q <= 1'b0;
			else if (nmi_edge)
				nmi_q <= 1'b1;
			else if (nmi_take)
				nmi_q <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_q <= 1'b0;
			ack_q <= 1'b0;
			ack_src_q <= 6'h00;
		end else if (ce) begin
			load_q <= (state_q == ST_VEC || state_q == ST_RSP) &&
				mem_ack && !dbg_reset_cmd;
			ack_q <= int_take;
			ack_src_q <= int_take ? win_idx : ack_src_q;
		end
	end
	// Core results
	assign core_busy = ~idle;
	assign core_load = load_q;
	assign core_pc = pc_tmp_q;
	assign core_sp = sp_q;
	assign int_ack = ack_q;
	assign int_ack_src = ack_src_q;
	// APB answer, zero wait states
	assign pready = ce;
	assign pslverr = apb_acc & ~hit_any;
	assign prdata = ~apb_acc ? 32'h0000_0000 :
		hit_vb ? vbase_q :
		hit_sw ? sword_q :
		hit_pr ? prio_q[pr_idx*32 +: 32] :
		hit_pd ? 32'(req) :
		hit_st ? {13'h0, core_busy, ae_pend_q, win_ok, 3'h0,
			win_lvl, 2'h0, win_idx} :
		32'h0000_0000;
endmodule

// *** dv/cpe_exc_unit_chk.sv ***
/*
 * Checker for cpe_exc_unit: reset fetch order, stacking order, take timing.
 * Sees only top-level ports; bound into every instance of the unit.
 */
`timescale 1ns/1ps
module cpe_exc_unit_chk import cpe_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Core side
	input wire logic dbg_reset_cmd,
	input wire logic insn_done,
	input wire logic [31:0] sp_in,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Results
	input wire logic core_busy,
	input wire logic core_load,
	input wire logic [31:0] core_sp,
	input wire logic int_ack
);
	logic [1:0] wr_n_q;
	logic [1:0] wr_n_d;
	wire logic wr_ack = ce && mem_req && mem_we && mem_ack && !dbg_reset_cmd;
	// Counts stack writes within one sequence
	assign wr_n_d = core_busy ? wr_n_q + {1'b0, wr_ack} : 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wr_n_q <= 2'h0;
		else
			wr_n_q <= wr_n_d;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_pc_ack;
		ce && !dbg_reset_cmd && mem_req && mem_ack && !mem_we &&
			mem_addr == RESET_BASE;
	endsequence
	sequence s_sp_ack;
		ce && !dbg_reset_cmd && mem_req && mem_ack && !mem_we &&
			mem_addr == RESET_BASE + SP_STEP;
	endsequence
	property p_rst_start;
		ce && dbg_reset_cmd |=> mem_req && !mem_we && mem_addr == RESET_BASE;
	endproperty
	a_rst_start: assert property (p_rst_start)
		else $error("reset fetch did not start");
	property p_rst_sp;
		s_pc_ack |=> mem_req && !mem_we && mem_addr == RESET_BASE + SP_STEP;
	endproperty
	a_rst_sp: assert property (p_rst_sp)
		else $error("stack pointer fetch out of order");
	property p_rst_load;
		s_sp_ack |=> core_load && core_sp == $past(mem_rdata);
	endproperty
	a_rst_load: assert property (p_rst_load)
		else $error("fetched stack pointer not loaded");
	property p_push_sr;
		int_ack |-> mem_req && mem_we && mem_addr == $past(sp_in) - SP_STEP;
	endproperty
	a_push_sr: assert property (p_push_sr)
		else $error("status push missing after acceptance");
	property p_push_pc;
		wr_n_q == 2'h0 && wr_ack |=>
			mem_req && mem_we && mem_addr == $past(mem_addr) - SP_STEP;
	endproperty
	a_push_pc: assert property (p_push_pc)
		else $error("counter push does not follow status push");
	property p_vec_rd;
		wr_n_q == 2'h1 && wr_ack |=> mem_req && !mem_we;
	endproperty
	a_vec_rd: assert property (p_vec_rd)
		else $error("vector read does not follow stacking");
	property p_take_done;
		$rose(core_busy) && mem_we |-> $past(insn_done);
	endproperty
	a_take_done: assert property (p_take_done)
		else $error("exception started inside an instruction");
	property p_ack_once;
		int_ack |=> !int_ack;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("acknowledge longer than one cycle");
	property p_load_end;
		core_load && !dbg_reset_cmd |=> !core_load && !core_busy;
	endproperty
	a_load_end: assert property (p_load_end)
		else $error("sequence continues after load");
endmodule
bind cpe_exc_unit cpe_exc_unit_chk u_chk (.pclk, .presetn, .ce,
	.dbg_reset_cmd, .insn_done, .sp_in, .mem_req, .mem_we, .mem_addr,
	.mem_rdata, .mem_ack, .core_busy, .core_load, .core_sp, .int_ack);

// *** dv/cpe_mem_model.sv ***
/*
 * Memory responder for the stacking and vector port.
 * Assumes one request at a time, held until acknowledged.
 */
`timescale 1ns/1ps
module cpe_mem_model #(
	parameter logic [31:0] PAT = 32'h0F0F_0F0F
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pace: high adds three wait cycles
	input wire logic slow,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [1:0] cnt_q;
	logic tgl_q;
	assign mem_ack = mem_req && (cnt_q == (slow ? 2'h3 : 2'h0));
	// Idle bus toggles so stale data never passes as valid
	assign mem_rdata = (mem_ack && !mem_we) ? mem_addr ^ PAT : {32{tgl_q}};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 2'h0;
			tgl_q <= 1'b0;
		end else begin
			cnt_q <= (mem_req && !mem_ack) ? cnt_q + 2'h1 : 2'h0;
			tgl_q <= !tgl_q;
		end
	end
endmodule

// *** dv/cpe_exc_unit_tb.sv ***
/*
 * Bench for cpe_exc_unit: debug reset, address errors, interrupt priority.
 * Assumes the memory responder model on the stacking port.
 */
`timescale 1ns/1ps
module cpe_exc_unit_tb import cpe_pkg::*; ;
	localparam logic [31:0] PAT = 32'h0F0F_0F0F;
	localparam logic [31:0] VB = 32'h0000_0400;
	localparam logic [31:0] SP = 32'h0000_8000;
	localparam logic [31:0] NPC = 32'h0000_2000;
	logic pclk, presetn, ce, psel, penable, pwrite, slow, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_v, acc_addr, insn_pc, mem_addr;
	logic [31:0] mem_wdata, mem_rdata, core_pc, core_sp;
	logic err_v, dbg_reset_cmd, acc_valid, insn_in_slot, insn_done;
	logic mem_req, mem_we, mem_ack, core_busy, core_load, int_ack;
	logic [1:0] acc_kind;
	logic [5:0] int_ack_src;
	logic [33:0] req;
	logic [64:0] lg[$];
	int error_cnt, n_checks;
	cpe_exc_unit dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .nmi_pin(req[0]),
		.brk_req(req[1]), .dbg_req(req[2]), .irq_pins(req[10:3]),
		.per_req(req[33:11]), .dbg_reset_cmd, .acc_valid, .acc_kind,
		.acc_addr, .insn_pc, .insn_in_slot, .slot_branch_pc(32'h0000_0300),
		.next_pc(NPC), .insn_done, .sp_in(SP), .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .core_busy, .core_load, .core_pc,
		.core_sp, .int_ack, .int_ack_src);
	cpe_mem_model #(.PAT(PAT)) mem (.pclk, .presetn, .slow, .mem_req,
		.mem_we, .mem_addr, .mem_rdata, .mem_ack);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Requesters hold until acknowledged
	always @(posedge pclk) begin
		if (mem_req && mem_ack && ce)
			lg.push_back({mem_we, mem_addr, mem_we ? mem_wdata : mem_rdata});
		if (int_ack)
			req[int_ack_src] <= 1'b0;
	end
	task automatic summarize;
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [64:0] s, input logic [64:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task automatic tmo;
		error_cnt++;
		$display("[ERR] %0t wait limit reached", $time);
		summarize;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready) break;
		end
		if (i == 50) tmo;
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt_load;
		int i;
		for (i = 0; i < 100 && core_load !== 1'b1; i++)
			@(negedge pclk);
		if (i == 100) tmo;
	endtask
	task automatic exc_chk(input logic [31:0] sw, pc, input logic [7:0] vec);
		logic [31:0] va;
		va = VB + {vec, 2'h0};
		wt_load;
		chk(lg[0], {1'b1, SP - SP_STEP, sw});
		chk(lg[1], {1'b1, SP - SP_STEP - SP_STEP, pc});
		chk(lg[2], {1'b0, va, va ^ PAT});
		chk({core_pc, core_sp}, {va ^ PAT, SP - SP_STEP - SP_STEP});
		lg.delete();
	endtask
	task automatic take(input int r, k, input logic [7:0] vec,
		input logic [3:0] lv, input logic [31:0] sw);
		int i;
		lg.delete();
		@(posedge pclk);
		if (r >= 0) req[r] <= 1'b1;
		for (i = 0; i < 50 && int_ack !== 1'b1; i++)
			@(negedge pclk);
		if (i == 50) tmo;
		chk(int_ack_src, k);
		exc_chk(sw, NPC, vec);
		apb(0, OFF_SWORD, 0);
		chk(rd_v, {24'h00_0000, lv, 4'h0});
	endtask
	task automatic t_regs;
		apb(0, OFF_VBASE, 0);
		chk(rd_v, VBASE_RST);
		apb(0, OFF_SWORD, 0);
		chk(rd_v, SWORD_RST);
		apb(1, OFF_VBASE, VB);
		apb(0, 8'h20, 0);
		chk(err_v, 1'b1);
	endtask
	task automatic t_dbg;
		logic [31:0] r;
		r = RESET_BASE + SP_STEP;
		apb(1, OFF_SWORD, 0);
		slow <= 1'b1;
		lg.delete();
		@(posedge pclk);
		dbg_reset_cmd <= 1'b1;
		@(posedge pclk);
		dbg_reset_cmd <= 1'b0;
		wt_load;
		chk(lg[0], {1'b0, RESET_BASE, RESET_BASE ^ PAT});
		chk(lg[1], {1'b0, r, r ^ PAT});
		chk({core_pc, core_sp}, {RESET_BASE ^ PAT, r ^ PAT});
		slow <= 1'b0;
		apb(0, OFF_VBASE, 0);
		chk(rd_v, 32'h0000_0000);
		apb(0, OFF_SWORD, 0);
		chk(rd_v, SWORD_RST);
		apb(1, OFF_VBASE, VB);
	endtask
	task automatic t_ae;
		logic [1:0] kd[8] = '{0, 0, 2, 2, 3, 3, 1, 2};
		logic [3:0] lo[8] = '{0, 1, 2, 3, 4, 6, 1, 5};
		logic [31:0] pc;
		int i;
		for (i = 0; i < 8; i++) begin
			pc = (i == 7) ? 32'h0000_0300 : 32'h0000_0100 + 2 * i;
			lg.delete();
			@(posedge pclk);
			acc_valid <= 1'b1;
			acc_kind <= kd[i];
			acc_addr <= 32'h0000_1000 + lo[i];
			insn_pc <= 32'h0000_0100 + 2 * i;
			insn_in_slot <= (i == 7);
			slow <= i[1];
			@(posedge pclk);
			acc_valid <= 1'b0;
			apb(0, OFF_STAT, 0);
			chk(rd_v, {14'h0, i[0], 17'h0});
			chk(core_busy, 1'b0);
			insn_done <= 1'b1;
			@(posedge pclk);
			insn_done <= 1'b0;
			if (i[0])
				exc_chk(SWORD_RST, pc, VEC_ADDR_ERR);
			else begin
				cyc(8);
				chk(lg.size(), 0);
			end
		end
	endtask
	task automatic t_irq;
		int sr[3] = '{7, 11, 2};
		logic [7:0] vc[3] = '{8'h50, 8'h54, VEC_DBG};
		logic [3:0] lvs[3] = '{4'h9, 4'h3, 4'hF};
		int i;
		apb(1, OFF_PRIO0, 32'h0009_0055);
		apb(1, OFF_PRIO0 + 8'h04, 32'h0000_0003);
		apb(1, OFF_SWORD, 32'h0000_0050);
		@(posedge pclk);
		insn_done <= 1'b1;
		req[4:3] <= 2'h3;
		cyc(6);
		chk(core_busy, 1'b0);
		apb(0, OFF_PEND, 0);
		chk(rd_v, 32'h0000_0018);
		apb(0, OFF_STAT, 0);
		chk(rd_v, 32'h0000_0000);
		apb(0, OFF_PRIO0, 0);
		chk(rd_v, 32'h0009_0055);
		apb(1, OFF_SWORD, 32'h0000_0040);
		take(-1, 3, VEC_IRQ_LO, 4'h5, 32'h0000_0040);
		cyc(6);
		chk(core_busy, 1'b0);
		apb(1, OFF_SWORD, 32'h0000_0040);
		take(-1, 4, 8'h41, 4'h5, 32'h0000_0040);
		for (i = 0; i < 3; i++) begin
			apb(1, OFF_SWORD, 0);
			take(sr[i], sr[i], vc[i], lvs[i], 0);
		end
		apb(1, OFF_SWORD, 32'h0000_00F0);
		@(posedge pclk);
		req[1] <= 1'b1;
		cyc(6);
		chk(core_busy, 1'b0);
		take(0, 0, VEC_NMI, 4'hF, 32'h0000_00F0);
		apb(1, OFF_SWORD, 32'h0000_00E0);
		take(-1, 1, VEC_BRK, 4'hF, 32'h0000_00E0);
	endtask
	initial begin
		{ce, presetn, psel, penable, pwrite, slow} = 6'h20;
		{dbg_reset_cmd, acc_valid, insn_in_slot, insn_done} = 4'h0;
		{paddr, pwdata, acc_addr, insn_pc, acc_kind, req} = '0;
		error_cnt = 0;
		n_checks = 0;
		cyc(20);
		presetn <= 1'b1;
		t_regs;
		t_dbg;
		t_ae;
		t_irq;
		summarize;
	end
endmodule
